// ### mlod_diag.sv
`timescale 1ns/1ps
`include "mlod_map.svh"
// ---------------------------------------------------------------
// Functional notes
// RL1: A coil whose target current is not reached gets an open flag that never alters drive.
// RL2: The open check only asks if commanded current is reached, so low supply may flag too.
// RL3: No open check is made while the motor stands still.
// RL4: The sensitivity offset is signed, up to +63, zero neutral, negative more sensitive.
// RL5: A higher offset raises the reading so more torque is needed to show a stall.
// RL6: With the filter on, one result is made per four full steps.
// RL7: The result is unsigned 0..1023, high means light load, zero means highest load.
// RL8: At maximum load the result falls to zero or near it.
// RL9: On stall the result is forced to zero and a stall pulse goes out on the chosen diag output.
// RL10: The outside controller stops the motor on a single stall pulse if it wants.
// RL11: Stall detection is suppressed outside the low and optional high velocity limits.
// RL12: Unfiltered, the result updates once per full step.
// RL13: The offset is a 7-bit two's-complement field sign-extended before use.
// ---------------------------------------------------------------
module mlod_diag
    import mlod_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire logic FULLSTEP_I,
    input wire logic [19:0] STEP_PERIOD_I,
    input wire logic STANDSTILL_I,
    input wire logic REACHED_A_I,
    input wire logic REACHED_B_I,
    input wire logic [9:0] RAW_LOAD_I,
    output logic OPEN_A_O,
    output logic OPEN_B_O,
    output logic DIAG_OUT_ZERO_O,
    output logic DIAG_OUT_ONE_O,
    output logic [9:0] LOAD_MEASURE_RESULT_O,
    output logic IRQ_O
);
    import mlod_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers, two stages each
    // ---------------------------------------------------------------
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [9:0] raw1;
    logic [9:0] raw2;
    logic step_prev;

    always_ff @(posedge CLK_I)
    begin
        if (!RESETN_I)
        begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            raw1 <= 10'h000;
            raw2 <= 10'h000;
            step_prev <= 1'b0;
        end
        else
        begin
            sync1 <= {FULLSTEP_I, STANDSTILL_I, REACHED_A_I, REACHED_B_I};
            sync2 <= sync1;
            raw1 <= RAW_LOAD_I;
            raw2 <= raw1;
            step_prev <= sync2[3];
        end
    end

    // raw load is sampled on the step edge, long after it settles
    wire step_pulse = sync2[3] && !step_prev;
    wire still = sync2[2];

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [31:0] ctrl;
    logic [19:0] low_velocity_limit;
    logic [19:0] high_velocity_limit;
    logic [`MLOD_NSTAT-1:0] status;
    logic [`MLOD_NSTAT-1:0] mask;
    mlod_bus_t bus_state;

    wire mlod_sgt_t stall_sensitivity_offset = ctrl[`MLOD_CTRL_SGT_MSB:`MLOD_CTRL_SGT_LSB];
    wire filt_en = ctrl[`MLOD_CTRL_FILT_BIT];
    wire high_en = ctrl[`MLOD_CTRL_HIEN_BIT];
    wire diag_sel = ctrl[`MLOD_CTRL_DIAG_BIT];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    wire wr_ctrl = AVS_WRITE_I && AVS_ADDRESS_I == `MLOD_CTRL_OFS;
    wire wr_vlow = AVS_WRITE_I && AVS_ADDRESS_I == `MLOD_VLOW_OFS;
    wire wr_vhigh = AVS_WRITE_I && AVS_ADDRESS_I == `MLOD_VHIGH_OFS;
    wire wr_stat = AVS_WRITE_I && AVS_ADDRESS_I == `MLOD_STAT_OFS;
    wire wr_mask = AVS_WRITE_I && AVS_ADDRESS_I == `MLOD_MASK_OFS;
    wire [31:0] wmerge_ctrl = merge(ctrl, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
    wire [31:0] wmerge_vlow = merge({12'h000, low_velocity_limit}, AVS_WRITEDATA_I,
                                    AVS_BYTEENABLE_I);
    wire [31:0] wmerge_vhigh = merge({12'h000, high_velocity_limit}, AVS_WRITEDATA_I,
                                     AVS_BYTEENABLE_I);

    // ---------------------------------------------------------------
    // coil checks and load value
    // ---------------------------------------------------------------
    logic open_a;
    logic open_b;
    logic meas_valid;
    logic [9:0] meas_value;

    mlod_open_coil u_coil_a
    (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .standstill_i(still),
        .reached_i(sync2[1]),
        .step_i(step_pulse),
        .open_o(open_a)
    );

    mlod_open_coil u_coil_b
    (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .standstill_i(still),
        .reached_i(sync2[0]),
        .step_i(step_pulse),
        .open_o(open_b)
    );

    mlod_load_calc u_load
    (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .step_i(step_pulse),
        .raw_i(raw2),
        .sgt_i(stall_sensitivity_offset),
        .filt_i(filt_en),
        .valid_o(meas_valid),
        .value_o(meas_value)
    );

    // ---------------------------------------------------------------
    // stall detection, velocity window
    // ---------------------------------------------------------------
    // step period grows as velocity falls: inside means fast enough, not too fast
    wire above_low = STEP_PERIOD_I <= low_velocity_limit;
    wire below_high = !high_en || STEP_PERIOD_I > high_velocity_limit;
    wire in_window = above_low && below_high && !still; // RL11
    wire stall_evt = meas_valid && meas_value == 10'h000 && in_window; // RL9

    logic [3:0] pulse_cnt;
    logic open_eval;
    wire pulse_on = pulse_cnt != 4'h0;

    // ---------------------------------------------------------------
    // sticky status, set beats clear
    // ---------------------------------------------------------------
    wire [`MLOD_NSTAT-1:0] events = {meas_valid, stall_evt, open_b, open_a};
    wire [`MLOD_NSTAT-1:0] clr = wr_stat ? AVS_WRITEDATA_I[`MLOD_NSTAT-1:0] : '0;
    wire [`MLOD_NSTAT-1:0] next_status = (status & ~clr) | events;
    // clear only at the acknowledge edge, like every other write
    wire [`MLOD_NSTAT-1:0] status_upd =
        (bus_state == MLOD_DONE) ? next_status : (status | events);

    always_ff @(posedge CLK_I)
    begin
        if (!RESETN_I)
        begin
            ctrl <= `MLOD_CTRL_RST;
            low_velocity_limit <= 20'h00000;
            high_velocity_limit <= 20'h00000;
            status <= '0;
            mask <= '0;
            IRQ_O <= 1'b0;
        end
        else
        begin
            if (wr_ctrl && bus_state == MLOD_DONE)
                ctrl <= wmerge_ctrl;
            if (wr_vlow && bus_state == MLOD_DONE)
                low_velocity_limit <= wmerge_vlow[19:0];
            if (wr_vhigh && bus_state == MLOD_DONE)
                high_velocity_limit <= wmerge_vhigh[19:0];
            if (wr_mask && bus_state == MLOD_DONE)
                mask <= AVS_WRITEDATA_I[`MLOD_NSTAT-1:0];
            status <= status_upd;
            IRQ_O <= |(status_upd & mask);
        end
    end

    // ---------------------------------------------------------------
    // outputs: flags and stall pulse, informative only
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (!RESETN_I)
        begin
            OPEN_A_O <= 1'b0;
            OPEN_B_O <= 1'b0;
            LOAD_MEASURE_RESULT_O <= 10'h000;
            pulse_cnt <= 4'h0;
            open_eval <= 1'b0;
            DIAG_OUT_ZERO_O <= 1'b0;
            DIAG_OUT_ONE_O <= 1'b0;
        end
        else
        begin
            // coil verdict lands one cycle after the step it judges
            open_eval <= step_pulse && !still; // RL3
            if (open_eval)
            begin
                OPEN_A_O <= open_a; // RL1
                OPEN_B_O <= open_b; // RL1
            end
            if (meas_valid)
                LOAD_MEASURE_RESULT_O <= meas_value; // RL7 RL9
            if (stall_evt)
                pulse_cnt <= 4'(`MLOD_STALL_PULSE_CYC); // RL9
            else if (pulse_on)
                pulse_cnt <= pulse_cnt - 4'h1;
            DIAG_OUT_ZERO_O <= (stall_evt || pulse_cnt > 4'h1) && !diag_sel; // RL9 RL10
            DIAG_OUT_ONE_O <= (stall_evt || pulse_cnt > 4'h1) && diag_sel; // RL9 RL10
        end
    end

    // ---------------------------------------------------------------
    // avalon slave: one wait state, reads zero when unmapped
    // ---------------------------------------------------------------
    wire [31:0] rd_mux =
        AVS_ADDRESS_I == `MLOD_CTRL_OFS ? ctrl :
        AVS_ADDRESS_I == `MLOD_VLOW_OFS ? {12'h000, low_velocity_limit} :
        AVS_ADDRESS_I == `MLOD_VHIGH_OFS ? {12'h000, high_velocity_limit} :
        AVS_ADDRESS_I == `MLOD_RESULT_OFS ? {22'h0, LOAD_MEASURE_RESULT_O} :
        AVS_ADDRESS_I == `MLOD_STAT_OFS ? {28'h0000000, status} :
        AVS_ADDRESS_I == `MLOD_MASK_OFS ? {28'h0000000, mask} : 32'h0000_0000;

    always_ff @(posedge CLK_I)
    begin
        if (!RESETN_I)
        begin
            bus_state <= MLOD_IDLE;
            AVS_READDATA_O <= 32'h0000_0000;
            AVS_WAITREQUEST_O <= 1'b1;
        end
        else
        begin
            unique case (bus_state)
                MLOD_IDLE:
                begin
                    if (AVS_READ_I || AVS_WRITE_I)
                    begin
                        AVS_READDATA_O <= rd_mux;
                        AVS_WAITREQUEST_O <= 1'b0;
                        bus_state <= MLOD_DONE;
                    end
                end
                MLOD_DONE:
                begin
                    AVS_WAITREQUEST_O <= 1'b1;
                    bus_state <= MLOD_IDLE;
                end
                default:
                    bus_state <= MLOD_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    chk_stall_zero: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RL9
        stall_evt |=> LOAD_MEASURE_RESULT_O == 10'h000 && (DIAG_OUT_ZERO_O || DIAG_OUT_ONE_O))
        else $error("stall without zero result or pulse");
    chk_window_gate: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RL11
        !in_window |-> !stall_evt) else $error("stall outside velocity window");
    chk_irq_level: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        |(status & mask) |-> ##[0:1] IRQ_O) else $error("irq not raised");
    chk_open_follow: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RL1
        open_eval |=> OPEN_A_O == $past(open_a) && OPEN_B_O == $past(open_b))
        else $error("open flag not taken from coil check");
    chk_diag_select: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // RL9
        stall_evt |=> ($past(diag_sel) ? DIAG_OUT_ONE_O && !DIAG_OUT_ZERO_O
                                       : DIAG_OUT_ZERO_O && !DIAG_OUT_ONE_O))
        else $error("stall pulse on wrong diag output");
    chk_write_on_ack: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        wr_ctrl && bus_state == MLOD_DONE |=> ctrl == $past(wmerge_ctrl))
        else $error("control write not applied at acknowledge");
    chk_ack_single: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
        !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O) else $error("acknowledge held too long");
endmodule // mlod_diag

// ### mlod_map.svh
`ifndef MLOD_MAP_SVH
`define MLOD_MAP_SVH
// ---------------------------------------------------------------
// register offsets (word addresses)
// ---------------------------------------------------------------
`define MLOD_CTRL_OFS 4'h0
`define MLOD_VLOW_OFS 4'h1
`define MLOD_VHIGH_OFS 4'h2
`define MLOD_RESULT_OFS 4'h3
`define MLOD_STAT_OFS 4'h4
`define MLOD_MASK_OFS 4'h5
// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define MLOD_CTRL_SGT_LSB 0
`define MLOD_CTRL_SGT_MSB 6
`define MLOD_CTRL_FILT_BIT 8
`define MLOD_CTRL_HIEN_BIT 9
`define MLOD_CTRL_DIAG_BIT 10
`define MLOD_CTRL_RST 32'h0000_0000
// ---------------------------------------------------------------
// status bits
// ---------------------------------------------------------------
`define MLOD_ST_OLA 0
`define MLOD_ST_OLB 1
`define MLOD_ST_STALL 2
`define MLOD_ST_UPD 3
`define MLOD_NSTAT 4
// ---------------------------------------------------------------
// timing and ranges
// ---------------------------------------------------------------
`define MLOD_STALL_PULSE_NS 100
`define MLOD_CLK_NS 10
`define MLOD_STALL_PULSE_CYC (`MLOD_STALL_PULSE_NS / `MLOD_CLK_NS)
`define MLOD_RESULT_MAX 10'h3ff
`define MLOD_SGT_STEP 5'd16
`define MLOD_FILT_STEPS 4
`endif

// ### mlod_pkg.sv
package mlod_pkg;
    typedef logic [9:0] mlod_result_t;
    typedef logic signed [6:0] mlod_sgt_t;
    typedef enum logic [1:0]
    {
        MLOD_IDLE = 2'b00,
        MLOD_READ = 2'b01,
        MLOD_DONE = 2'b10
    } mlod_bus_t;
endpackage

// ### mlod_open_coil.sv
`timescale 1ns/1ps
module mlod_open_coil
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic standstill_i,
    input wire logic reached_i,
    input wire logic step_i,
    output logic open_o
);
    // ---------------------------------------------------------------
    // per coil: any full step outside standstill without reaching target current flags
    // ---------------------------------------------------------------
    logic seen;
    wire eval = step_i && !standstill_i;

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            seen <= 1'b0;
            open_o <= 1'b0;
        end
        else
        begin
            if (eval)
                seen <= 1'b0;
            else if (reached_i && !standstill_i)
                seen <= 1'b1;
            open_o <= eval && !(seen || reached_i); // RL1 RL2 RL3
        end
    end

    chk_no_flag_still: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL3
        $past(standstill_i) |-> !open_o) else $error("open flag at standstill");
endmodule // mlod_open_coil

// ### mlod_load_calc.sv
`timescale 1ns/1ps
`include "mlod_map.svh"
module mlod_load_calc
    import mlod_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic step_i,
    input wire logic [9:0] raw_i,
    input wire mlod_pkg::mlod_sgt_t sgt_i,
    input wire logic filt_i,
    output logic valid_o,
    output logic [9:0] value_o
);
    // ---------------------------------------------------------------
    // offset: each sgt unit moves the reading by a fixed step
    // ---------------------------------------------------------------
    wire signed [12:0] sgt_ext = 13'(sgt_i); // RL13
    wire signed [12:0] adj =
        $signed({3'b000, raw_i}) + sgt_ext * $signed(13'(`MLOD_SGT_STEP)); // RL4 RL5
    wire [9:0] clip =
        adj < 0 ? 10'h000 : (adj > 13'sh3ff ? `MLOD_RESULT_MAX : adj[9:0]); // RL7 RL8

    logic [11:0] acc;
    logic [1:0] cnt;
    wire [11:0] acc_sum = acc + {2'b00, clip};

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            acc <= 12'h000;
            cnt <= 2'h0;
            valid_o <= 1'b0;
            value_o <= 10'h000;
        end
        else
        begin
            valid_o <= 1'b0;
            if (step_i && !filt_i)
            begin
                value_o <= clip; // RL12
                valid_o <= 1'b1;
                cnt <= 2'h0;
                acc <= 12'h000;
            end
            else if (step_i)
            begin
                cnt <= cnt + 2'h1;
                if (cnt == 2'h3)
                begin
                    value_o <= acc_sum[11:2]; // RL6
                    valid_o <= 1'b1;
                    acc <= 12'h000;
                end
                else
                    acc <= acc_sum;
            end
        end
    end

    chk_range_top: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL8
        step_i && !filt_i && raw_i == 10'h000 && sgt_i == 7'sh00 |=> value_o == 10'h000)
        else $error("zero raw not passed");
    chk_unfilt_update: assert property (@(posedge clk_i) disable iff (!resetn_i) // RL12
        step_i && !filt_i |=> valid_o && value_o == $past(clip))
        else $error("unfiltered step gave no result");
endmodule // mlod_load_calc

// ### mlod_ctrl_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// motion controller watching the stall outputs
// ---------------------------------------------------------------
module mlod_ctrl_model
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic diag_zero_i,
    input wire logic diag_one_i,
    output logic stop_o,
    output logic [7:0] zero_pulses_o,
    output logic [7:0] one_pulses_o
);
    logic zero_d;
    logic one_d;
    wire logic zero_rise = diag_zero_i & ~zero_d;
    wire logic one_rise = diag_one_i & ~one_d;
    always_ff @(posedge clk_i)
    begin
        zero_d <= diag_zero_i;
        one_d <= diag_one_i;
        if (!resetn_i)
        begin
            stop_o <= 1'b0;
            zero_pulses_o <= 8'h00;
            one_pulses_o <= 8'h00;
        end
        else
        begin
            zero_pulses_o <= zero_pulses_o + {7'h00, zero_rise};
            one_pulses_o <= one_pulses_o + {7'h00, one_rise};
            // one pulse is enough; no confirmation is awaited
            if (zero_rise || one_rise)
                stop_o <= 1'b1;
        end
    end
endmodule // mlod_ctrl_model

// ### mlod_diag_tb_top.sv
`timescale 1ns/1ps
`include "mlod_map.svh"
module mlod_diag_tb_top;
    import mlod_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hf;
    logic fullstep = 1'b0;
    logic [19:0] period = 20'h00064;
    logic standstill = 1'b1;
    logic rea = 1'b0;
    logic reb = 1'b0;
    logic [9:0] raw = 10'h000;
    logic [31:0] rdata;
    logic waitreq;
    logic open_a;
    logic open_b;
    logic d0;
    logic d1;
    logic [9:0] res;
    logic irq;
    logic stop;
    logic [7:0] zc;
    logic [7:0] oc;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int upd;
    logic [31:0] q;
    logic [6:0] sgt_tab [4] = '{7'h3f, 7'h01, 7'h7f, 7'h40};
    logic [9:0] exp_tab [4] = '{10'h3ff, 10'h204, 10'h1e4, 10'h000};

    mlod_diag mlod_diag_i (.CLK_I(clk), .RESETN_I(resetn), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .FULLSTEP_I(fullstep),
        .STEP_PERIOD_I(period), .STANDSTILL_I(standstill), .REACHED_A_I(rea),
        .REACHED_B_I(reb), .RAW_LOAD_I(raw), .OPEN_A_O(open_a), .OPEN_B_O(open_b),
        .DIAG_OUT_ZERO_O(d0), .DIAG_OUT_ONE_O(d1), .LOAD_MEASURE_RESULT_O(res), .IRQ_O(irq));
    mlod_ctrl_model mlod_ctrl_model_i (.clk_i(clk), .resetn_i(resetn), .diag_zero_i(d0),
        .diag_one_i(d1), .stop_o(stop), .zero_pulses_o(zc), .one_pulses_o(oc));

    always #5 clk = ~clk;
    // ---------------------------------------------------------------
    // hang guard, far above the several hundred cycles the run needs
    // ---------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            $display("[ERR] timeout");
            print_verdict();
        end
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= b;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rchk(input string name, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(name, e, q);
    endtask
    // raw load settles well before the edge and holds past the update
    task automatic step(input logic [9:0] r);
        raw <= r;
        repeat (4) @(posedge clk);
        fullstep <= 1'b1;
        repeat (4) @(posedge clk);
        fullstep <= 1'b0;
        repeat (20) @(posedge clk);
    endtask
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rchk("ctrl", `MLOD_CTRL_OFS, `MLOD_CTRL_RST);
        rchk("status", `MLOD_STAT_OFS, 32'h0);
        rchk("unmapped", 4'h6, 32'h0);
        bus(1'b1, `MLOD_CTRL_OFS, 32'h0000_073f, 4'h1);
        rchk("ctrl lane", `MLOD_CTRL_OFS, 32'h0000_003f);
        wreg(`MLOD_CTRL_OFS, 32'h0);
        $display("test map done");

        step(10'd500);
        chk("open a still", 32'h0, {31'h0, open_a});
        chk("open b still", 32'h0, {31'h0, open_b});
        standstill <= 1'b0;
        reb <= 1'b1;
        step(10'd500);
        chk("open a", 32'h1, {31'h0, open_a});
        chk("open b", 32'h0, {31'h0, open_b});
        chk("result", 32'd500, {22'h0, res});
        rchk("result reg", `MLOD_RESULT_OFS, 32'd500);
        rchk("status open", `MLOD_STAT_OFS, 32'h9);
        wreg(`MLOD_STAT_OFS, 32'hf);
        rchk("status clr", `MLOD_STAT_OFS, 32'h0);
        rea <= 1'b1;
        $display("test open coil done");

        for (int i = 0; i < 4; i++)
        begin
            wreg(`MLOD_CTRL_OFS, {25'h0, sgt_tab[i]});
            step(10'd500);
            chk("offset result", {22'h0, exp_tab[i]}, {22'h0, res});
        end
        chk("no stall", 32'h0, {24'h0, zc});
        $display("test offset done");

        wreg(`MLOD_CTRL_OFS, 32'h100);
        repeat (4) step(10'd400);
        wreg(`MLOD_STAT_OFS, 32'hf);
        upd = 0;
        for (int i = 0; i < 4; i++)
        begin
            step(10'd400);
            bus(1'b0, `MLOD_STAT_OFS, 32'h0, 4'hf);
            upd += int'(q[`MLOD_ST_UPD] === 1'b1);
            wreg(`MLOD_STAT_OFS, 32'h8);
        end
        chk("filter updates", 32'd1, upd);
        chk("filter result", 32'd400, {22'h0, res});
        $display("test filter done");

        wreg(`MLOD_CTRL_OFS, 32'h0);
        wreg(`MLOD_VLOW_OFS, 32'd200);
        wreg(`MLOD_STAT_OFS, 32'hf);
        // zero raw load at neutral offset reads as a stall
        step(10'd0);
        chk("stall result", 32'h0, {22'h0, res});
        chk("pulse zero", 32'h1, {24'h0, zc});
        chk("pulse one", 32'h0, {24'h0, oc});
        chk("stopped", 32'h1, {31'h0, stop});
        rchk("status stall", `MLOD_STAT_OFS, 32'hc);
        chk("irq masked", 32'h0, {31'h0, irq});
        wreg(`MLOD_MASK_OFS, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq on", 32'h1, {31'h0, irq});
        wreg(`MLOD_STAT_OFS, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq off", 32'h0, {31'h0, irq});
        wreg(`MLOD_CTRL_OFS, 32'h400);
        step(10'd0);
        chk("pulse one sel", 32'h1, {24'h0, oc});
        chk("pulse zero sel", 32'h1, {24'h0, zc});
        $display("test stall done");

        wreg(`MLOD_CTRL_OFS, 32'h600);
        wreg(`MLOD_VHIGH_OFS, 32'd150);
        step(10'd0);
        chk("too fast", 32'h1, {24'h0, oc});
        period <= 20'd180;
        step(10'd0);
        chk("in window", 32'h0, {22'h0, res});
        chk("in window pulse", 32'h2, {24'h0, oc});
        period <= 20'd250;
        wreg(`MLOD_STAT_OFS, 32'hf);
        step(10'd0);
        rchk("too slow", `MLOD_STAT_OFS, 32'h8);
        chk("too slow pulse", 32'h2, {24'h0, oc});
        $display("test window done");
        print_verdict();
    end
endmodule // mlod_diag_tb_top
